//--- logic/pmsa_cfg.svh
// offsets, field positions, reset values and timing counts of the monitor core
`ifndef PMSA_CFG_SVH
`define PMSA_CFG_SVH
// register offsets
`define PMSA_OFS_CONFIG 3'h0
`define PMSA_OFS_SHUNT 3'h1
`define PMSA_OFS_BUS 3'h2
`define PMSA_OFS_POWER 3'h3
`define PMSA_OFS_CURRENT 3'h4
`define PMSA_OFS_CALIB 3'h5
`define PMSA_OFS_MASK 3'h6
`define PMSA_OFS_LIMIT 3'h7
// configuration fields
`define PMSA_CFG_MODE 2:0
`define PMSA_CFG_SHUNT_CT 5:3
`define PMSA_CFG_BUS_CT 8:6
`define PMSA_CFG_AVG 11:9
// alert mask and enable fields
`define PMSA_ME_FUNC 15:11
`define PMSA_ME_CONV_READY_ALERT_ENABLE 10
`define PMSA_ME_AFF 4
`define PMSA_ME_CONV_READY_FLAG 3
`define PMSA_ME_ALERT_POLARITY 1
`define PMSA_ME_LEN 0
// reset values
`define PMSA_RST_CONFIG 16'h4127
`define PMSA_RST_ZERO 16'h0000
// timing
`define PMSA_CLK_MHZ 20
`define PMSA_WAKE_US 40
`define PMSA_CT_US {14'd8244, 14'd4156, 14'd2116, 14'd1100, 14'd588, 14'd332, 14'd204, 14'd140}
// current and power scaling
`define PMSA_CUR_SHIFT 11
`define PMSA_POW_DIV 32'd20000
`endif

//--- logic/pmsa_pkg.sv
// types of the monitor core
package pmsa_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_WAKE = 5'b00010,
    ST_SHUNT = 5'b00100,
    ST_BUS = 5'b01000,
    ST_ACC = 5'b10000
  } pmsa_state_type;
endpackage : pmsa_pkg

//--- logic/pmsa_core.sv
// sequencer, averaging, scaling and alert logic of the power monitor
//
// How it works
// (R01) mode 111 repeats measurement sequences with no further host action
// (R02) shunt converted first, bus second, then current and power; sums accumulated
// (R03) result registers load only when averaging completes, else hold
// (R04) a config write of mode 001/010/011 runs exactly one measurement set
// (R05) mode bits 0 and 1 select shunt only, bus only, or both
// (R06) registers stay accessible in power-down; active write exits after 40 us
// (R07) ready flag sets after conversions, averaging and multiplication finish
// (R08) ready flag clears on non-power-down config write or mask register read
// (R09) shunt and bus conversion times chosen separately, 140 us to 8.244 ms
// (R10) current is shunt scaled by calibration; zero while calibration is zero
// (R11) power is current times bus, computed in the background; zero uncalibrated
// (R12) with averaging above one, samples go to accumulators, not result registers
// (R13) enable bits pick one of five limit functions against the limit register
// (R14) highest enabled function bit alone drives the alert
// (R15) shunt compared to limit after every shunt conversion
// (R16) bus voltage compared to limit after every bus conversion
// (R17) power compared to limit after every bus conversion
// (R18) host reads ready flag bit 3 and function flag bit 4 for the source
// (R19) ready flag reaches the alert only when its alert enable is set
// (R20) polarity bit 1 of mask register sets the asserted alert level
// (R21) latched flag and alert hold until mask read or config write
// (R22) current equals shunt times calibration divided by 2048
// (R23) power equals current times bus divided by 20000
// (R24) averaging and enable encodings fixed in the core
`timescale 1ns/1ns
`include "pmsa_cfg.svh"
module pmsa_core #(
  parameter int TICKS_PER_US = `PMSA_CLK_MHZ
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // register port from the serial engine
  input wire logic [2:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_RD,
  output logic [15:0] REG_RDATA,
  // converter samples and control
  input wire logic [15:0] SHUNT_SAMPLE,
  input wire logic [15:0] BUS_SAMPLE,
  output logic ANALOG_ON,
  // open-drain alert pin
  output logic ALERT_OUT,
  output logic ALERT_OE_N
);
  localparam logic [7:0][13:0] CT_US = `PMSA_CT_US;
  localparam int WAKE_CYC = `PMSA_WAKE_US * TICKS_PER_US;
  localparam logic [15:0] RST_CFG = `PMSA_RST_CONFIG;
  localparam logic [23:0] RST_CNT = 24'(CT_US[RST_CFG[`PMSA_CFG_SHUNT_CT]] * TICKS_PER_US) - 24'h000001;

  if (TICKS_PER_US < 1 || TICKS_PER_US > 100) begin : g_bad_ticks
    $error("TICKS_PER_US out of range");
  end

  pmsa_pkg::pmsa_state_type state_q;
  logic [23:0] cnt_q;
  logic [10:0] nsamp_q;
  logic pd_q;
  logic [15:0] cfg_q;
  logic [15:0] cal_q;
  logic [15:0] lim_q;
  logic [5:0] me_en_q;
  logic alert_polarity_q;
  logic len_q;
  logic conv_ready_flag_q;
  logic aff_q;
  logic [15:0] smp_sh_q;
  logic [15:0] smp_bu_q;
  logic signed [25:0] acc_sh_q;
  logic signed [25:0] acc_bu_q;
  logic signed [25:0] acc_cu_q;
  logic signed [25:0] acc_pw_q;
  logic [15:0] shunt_q;
  logic [15:0] bus_q;
  logic [15:0] cur_q;
  logic [15:0] pow_q;
  logic [15:0] rdata_q;
  logic alert_oe_n_q;

  // register port decode
  logic cfg_wr;
  logic me_rd;
  logic new_active;
  assign cfg_wr = REG_WR && (REG_ADDR == `PMSA_OFS_CONFIG);
  assign me_rd = REG_RD && (REG_ADDR == `PMSA_OFS_MASK);
  assign new_active = REG_WDATA[1:0] != 2'b00;

  // sequencer events
  logic cnt_zero;
  logic shunt_end;
  logic bus_end;
  logic acc_step;
  logic last_smp;
  assign cnt_zero = cnt_q == 24'h000000;
  assign shunt_end = (state_q == pmsa_pkg::ST_SHUNT) && cnt_zero;
  assign bus_end = (state_q == pmsa_pkg::ST_BUS) && cnt_zero;
  assign acc_step = (state_q == pmsa_pkg::ST_ACC) && !cfg_wr;

  // averaging count and shift from config
  logic [3:0] avg_shift;
  always_comb begin
    unique case (cfg_q[`PMSA_CFG_AVG])
      3'h0: avg_shift = 4'h0;
      3'h1: avg_shift = 4'h2;
      3'h2: avg_shift = 4'h4;
      3'h3: avg_shift = 4'h6;
      3'h4: avg_shift = 4'h7;
      3'h5: avg_shift = 4'h8;
      3'h6: avg_shift = 4'h9;
      3'h7: avg_shift = 4'hA;
    endcase
  end
  assign last_smp = ({5'h00, nsamp_q} + 16'h0001) == (16'h0001 << avg_shift); // [R24]

  // conversion time in cycles for a code
  function automatic logic [23:0] ct_cyc(input logic [2:0] code);
    ct_cyc = 24'(CT_US[code] * TICKS_PER_US) - 24'h000001; // [R09]
  endfunction : ct_cyc

  // first state of a sequence for a config value
  function automatic pmsa_pkg::pmsa_state_type first_st(input logic [15:0] c);
    first_st = c[0] ? pmsa_pkg::ST_SHUNT : pmsa_pkg::ST_BUS; // [R02] [R05]
  endfunction : first_st

  function automatic logic [23:0] first_cnt(input logic [15:0] c);
    first_cnt = c[0] ? ct_cyc(c[`PMSA_CFG_SHUNT_CT]) : ct_cyc(c[`PMSA_CFG_BUS_CT]);
  endfunction : first_cnt

  // sequencer state and timer
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= pmsa_pkg::ST_SHUNT;
      cnt_q <= RST_CNT; // [R09]
      pd_q <= 1'b0;
    end else if (cfg_wr) begin
      if (!new_active) begin
        state_q <= pmsa_pkg::ST_IDLE;
        pd_q <= 1'b1;
      end else if (pd_q) begin
        state_q <= pmsa_pkg::ST_WAKE; // [R06]
        cnt_q <= 24'(WAKE_CYC - 1);
        pd_q <= 1'b0;
      end else begin
        state_q <= first_st(REG_WDATA); // [R04]
        cnt_q <= first_cnt(REG_WDATA);
      end
    end else begin
      unique case (state_q)
        pmsa_pkg::ST_IDLE: begin
          cnt_q <= 24'h000000;
        end
        pmsa_pkg::ST_WAKE: begin
          if (cnt_zero) begin
            state_q <= first_st(cfg_q);
            cnt_q <= first_cnt(cfg_q);
          end else begin
            cnt_q <= cnt_q - 24'h000001;
          end
        end
        pmsa_pkg::ST_SHUNT: begin
          if (!cnt_zero) begin
            cnt_q <= cnt_q - 24'h000001;
          end else if (cfg_q[1]) begin
            state_q <= pmsa_pkg::ST_BUS; // [R02]
            cnt_q <= ct_cyc(cfg_q[`PMSA_CFG_BUS_CT]);
          end else begin
            state_q <= pmsa_pkg::ST_ACC;
          end
        end
        pmsa_pkg::ST_BUS: begin
          if (!cnt_zero) begin
            cnt_q <= cnt_q - 24'h000001;
          end else begin
            state_q <= pmsa_pkg::ST_ACC;
          end
        end
        pmsa_pkg::ST_ACC: begin
          if (!last_smp || cfg_q[2]) begin
            state_q <= first_st(cfg_q); // [R01]
            cnt_q <= first_cnt(cfg_q);
          end else begin
            state_q <= pmsa_pkg::ST_IDLE; // [R04]
          end
        end
      endcase
    end
  end

  // current and power of the latest sample
  logic signed [31:0] cur_prod;
  logic signed [15:0] cur_now;
  logic [15:0] bus_now;
  logic [15:0] cur_mag;
  logic [31:0] pow_prod;
  logic [15:0] pow_now;
  assign cur_prod = $signed(smp_sh_q) * $signed({1'b0, cal_q[14:0]});
  assign cur_now = 16'(cur_prod >>> `PMSA_CUR_SHIFT); // [R10] [R22]
  assign bus_now = bus_end ? BUS_SAMPLE : smp_bu_q;
  assign cur_mag = cur_now[15] ? 16'(-cur_now) : cur_now;
  assign pow_prod = cur_mag * bus_now;
  assign pow_now = 16'(pow_prod / `PMSA_POW_DIV); // [R11] [R23]

  // samples, accumulators and result registers
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      smp_sh_q <= `PMSA_RST_ZERO;
      smp_bu_q <= `PMSA_RST_ZERO;
      nsamp_q <= 11'h000;
      acc_sh_q <= 26'sh0000000;
      acc_bu_q <= 26'sh0000000;
      acc_cu_q <= 26'sh0000000;
      acc_pw_q <= 26'sh0000000;
      shunt_q <= `PMSA_RST_ZERO;
      bus_q <= `PMSA_RST_ZERO;
      cur_q <= `PMSA_RST_ZERO;
      pow_q <= `PMSA_RST_ZERO;
    end else begin
      if (shunt_end) begin
        smp_sh_q <= SHUNT_SAMPLE;
      end
      if (bus_end) begin
        smp_bu_q <= BUS_SAMPLE;
      end
      if (cfg_wr || (acc_step && last_smp)) begin
        nsamp_q <= 11'h000;
        acc_sh_q <= 26'sh0000000;
        acc_bu_q <= 26'sh0000000;
        acc_cu_q <= 26'sh0000000;
        acc_pw_q <= 26'sh0000000;
      end else if (acc_step) begin
        nsamp_q <= nsamp_q + 11'h001;
        acc_sh_q <= acc_sh_q + 26'($signed(smp_sh_q)); // [R12]
        acc_bu_q <= acc_bu_q + 26'($signed(smp_bu_q));
        acc_cu_q <= acc_cu_q + 26'(cur_now);
        acc_pw_q <= acc_pw_q + 26'($signed({1'b0, pow_now}));
      end
      if (acc_step && last_smp) begin
        shunt_q <= 16'((acc_sh_q + 26'($signed(smp_sh_q))) >>> avg_shift); // [R03]
        bus_q <= 16'((acc_bu_q + 26'($signed(smp_bu_q))) >>> avg_shift);
        cur_q <= 16'((acc_cu_q + 26'(cur_now)) >>> avg_shift);
        pow_q <= 16'((acc_pw_q + 26'($signed({1'b0, pow_now}))) >>> avg_shift);
      end
    end
  end

  // writable registers
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cfg_q <= `PMSA_RST_CONFIG;
      cal_q <= `PMSA_RST_ZERO;
      lim_q <= `PMSA_RST_ZERO;
      me_en_q <= 6'h00;
      alert_polarity_q <= 1'b0;
      len_q <= 1'b0;
    end else if (REG_WR) begin
      unique case (REG_ADDR)
        `PMSA_OFS_CONFIG: cfg_q <= REG_WDATA;
        `PMSA_OFS_CALIB: cal_q <= {1'b0, REG_WDATA[14:0]};
        `PMSA_OFS_LIMIT: lim_q <= REG_WDATA; // [R13]
        `PMSA_OFS_MASK: begin
          me_en_q <= REG_WDATA[15:10];
          alert_polarity_q <= REG_WDATA[`PMSA_ME_ALERT_POLARITY];
          len_q <= REG_WDATA[`PMSA_ME_LEN];
        end
        default: begin
        end
      endcase
    end
  end

  // limit comparison for the selected function
  logic hit_ev;
  logic hit;
  always_comb begin
    hit_ev = 1'b0;
    hit = 1'b0;
    if (me_en_q[5]) begin // [R14]
      hit_ev = shunt_end;
      hit = $signed(SHUNT_SAMPLE) > $signed(lim_q); // [R15]
    end else if (me_en_q[4]) begin
      hit_ev = shunt_end;
      hit = $signed(SHUNT_SAMPLE) < $signed(lim_q); // [R15]
    end else if (me_en_q[3]) begin
      hit_ev = bus_end;
      hit = BUS_SAMPLE > lim_q; // [R16]
    end else if (me_en_q[2]) begin
      hit_ev = bus_end;
      hit = BUS_SAMPLE < lim_q; // [R16]
    end else if (me_en_q[1]) begin
      hit_ev = bus_end;
      hit = pow_now > lim_q; // [R17]
    end
  end

  // ready and function flags; a set wins over a clear
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      conv_ready_flag_q <= 1'b0;
      aff_q <= 1'b0;
    end else begin
      if (acc_step && last_smp) begin
        conv_ready_flag_q <= 1'b1; // [R07]
      end else if ((cfg_wr && new_active) || me_rd) begin
        conv_ready_flag_q <= 1'b0; // [R08]
      end
      if (hit_ev && hit) begin
        aff_q <= 1'b1;
      end else if (hit_ev && !len_q) begin
        aff_q <= 1'b0;
      end else if (len_q && (cfg_wr || me_rd)) begin
        aff_q <= 1'b0; // [R21]
      end else if (!len_q && me_en_q[5:1] == 5'h00) begin
        aff_q <= 1'b0;
      end
    end
  end

  // alert pin: asserted level set by polarity
  logic alert_act;
  assign alert_act = aff_q || (me_en_q[0] && conv_ready_flag_q); // [R19] [R18]
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      alert_oe_n_q <= 1'b1;
    end else begin
      alert_oe_n_q <= !(alert_act ^ alert_polarity_q); // [R20]
    end
  end

  // read data
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_q <= `PMSA_RST_ZERO;
    end else if (REG_RD) begin
      unique case (REG_ADDR)
        `PMSA_OFS_CONFIG: rdata_q <= cfg_q;
        `PMSA_OFS_SHUNT: rdata_q <= shunt_q;
        `PMSA_OFS_BUS: rdata_q <= bus_q;
        `PMSA_OFS_POWER: rdata_q <= pow_q;
        `PMSA_OFS_CURRENT: rdata_q <= cur_q;
        `PMSA_OFS_CALIB: rdata_q <= cal_q;
        `PMSA_OFS_MASK: rdata_q <= {me_en_q, 5'h00, aff_q, conv_ready_flag_q, 1'b0, alert_polarity_q, len_q};
        `PMSA_OFS_LIMIT: rdata_q <= lim_q;
      endcase
    end
  end

  // analog enable follows power-down state
  logic analog_on_q;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      analog_on_q <= 1'b0;
    end else begin
      analog_on_q <= !pd_q; // [R06]
    end
  end

  assign REG_RDATA = rdata_q;
  assign ALERT_OE_N = alert_oe_n_q;
  assign ALERT_OUT = 1'b0;
  assign ANALOG_ON = analog_on_q;
endmodule : pmsa_core

//--- verif/pmsa_frontend.sv
// converter front end model feeding samples to the monitor core
`timescale 1ns/1ns
module pmsa_frontend (
  // clock
  input wire logic clk,
  // converter power and levels
  input wire logic analog_on,
  input wire logic [15:0] shunt_level,
  input wire logic [15:0] bus_level,
  // samples to the core
  output logic [15:0] shunt_sample,
  output logic [15:0] bus_sample
);
  logic [15:0] junk_q = 16'h5AA5;
  // powered down: no settled value, pattern flips each cycle
  always_ff @(posedge clk) begin
    junk_q <= ~junk_q;
  end
  assign shunt_sample = analog_on ? shunt_level : junk_q;
  assign bus_sample = analog_on ? bus_level : ~junk_q;
endmodule : pmsa_frontend

//--- verif/pmsa_core_monitor.sv
// assertion checker on the monitor core ports
`timescale 1ns/1ns
`include "pmsa_cfg.svh"
module pmsa_core_monitor (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // register port
  input wire logic [2:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_RD,
  input wire logic [15:0] REG_RDATA,
  // converter and alert
  input wire logic [15:0] SHUNT_SAMPLE,
  input wire logic [15:0] BUS_SAMPLE,
  input wire logic ANALOG_ON,
  input wire logic ALERT_OUT,
  input wire logic ALERT_OE_N
);
  logic [15:0] cfg_q;
  logic [15:0] lim_q;
  logic [15:0] msk_q;
  logic wr_cfg;
  assign wr_cfg = REG_WR && REG_ADDR == `PMSA_OFS_CONFIG;
  // shadows of the host writes
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cfg_q <= `PMSA_RST_CONFIG;
      lim_q <= 16'h0000;
      msk_q <= 16'h0000;
    end else if (REG_WR) begin
      if (REG_ADDR == `PMSA_OFS_CONFIG) cfg_q <= REG_WDATA;
      if (REG_ADDR == `PMSA_OFS_LIMIT) lim_q <= REG_WDATA;
      if (REG_ADDR == `PMSA_OFS_MASK) msk_q <= REG_WDATA;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  a_alert_data_low: assert property (ALERT_OUT == 1'b0) else $error("alert data not low");
  a_pd_analog_off: assert property (wr_cfg && REG_WDATA[1:0] == 2'h0 |-> ##2 !ANALOG_ON)
    else $error("power-down write left converter on");
  a_wake_analog_on: assert property (wr_cfg && REG_WDATA[1:0] != 2'h0 |-> ##2 ANALOG_ON)
    else $error("active write left converter off");
  a_cfg_read_back: assert property (REG_RD && REG_ADDR == `PMSA_OFS_CONFIG |=>
    REG_RDATA[11:0] == $past(cfg_q[11:0])) else $error("config read mismatch");
  a_limit_read_back: assert property (REG_RD && REG_ADDR == `PMSA_OFS_LIMIT |=>
    REG_RDATA == $past(lim_q)) else $error("limit read mismatch");
  a_rdata_hold: assert property (!REG_RD |=> $stable(REG_RDATA)) else $error("read data moved");
  a_mask_fixed_zero: assert property (REG_RD && REG_ADDR == `PMSA_OFS_MASK |=>
    REG_RDATA[9:5] == 5'h00 && !REG_RDATA[2]) else $error("mask fixed bits set");
  a_mask_read_back: assert property (REG_RD && REG_ADDR == `PMSA_OFS_MASK |=>
    {REG_RDATA[15:10], REG_RDATA[1:0]} == {$past(msk_q[15:10]), $past(msk_q[1:0])})
    else $error("mask read mismatch");
  a_calib_top_zero: assert property (REG_RD && REG_ADDR == `PMSA_OFS_CALIB |=> !REG_RDATA[15])
    else $error("calibration top bit set");
  a_alert_idle_level: assert property ((msk_q[15:10] == 6'h00 && !msk_q[0])[*3] |->
    ALERT_OE_N == !msk_q[1]) else $error("idle alert level wrong");
  c_alert_low: cover property (!ALERT_OE_N);
  c_pd_write: cover property (wr_cfg && REG_WDATA[1:0] == 2'h0);
  c_mask_read: cover property (REG_RD && REG_ADDR == `PMSA_OFS_MASK);
endmodule : pmsa_core_monitor

//--- verif/tb_top.sv
// self-checking bench of the monitor core
`timescale 1ns/1ns
`include "pmsa_cfg.svh"
module tb_top;
  logic CLK;
  logic RST_N;
  logic [2:0] REG_ADDR;
  logic REG_WR;
  logic [15:0] REG_WDATA;
  logic REG_RD;
  logic [15:0] REG_RDATA;
  logic [15:0] SHUNT_SAMPLE;
  logic [15:0] BUS_SAMPLE;
  logic ANALOG_ON;
  logic ALERT_OUT;
  logic ALERT_OE_N;
  logic [15:0] shunt_level;
  logic [15:0] bus_level;
  int n_fail;
  int comparisons;
  pmsa_core #(.TICKS_PER_US(1)) pmsa_core_i (.CLK(CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
    .REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .SHUNT_SAMPLE(SHUNT_SAMPLE),
    .BUS_SAMPLE(BUS_SAMPLE), .ANALOG_ON(ANALOG_ON), .ALERT_OUT(ALERT_OUT), .ALERT_OE_N(ALERT_OE_N));
  pmsa_frontend pmsa_frontend_i (.clk(CLK), .analog_on(ANALOG_ON), .shunt_level(shunt_level),
    .bus_level(bus_level), .shunt_sample(SHUNT_SAMPLE), .bus_sample(BUS_SAMPLE));
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  task automatic final_report;
    if (n_fail == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", w, e, g);
    end
  endtask : chk
  task automatic chk_span(input string w, input int lo, input int hi, input int g);
    comparisons++;
    if (g < lo || g > hi) begin
      n_fail++;
      $display("Error %s expected %0d..%0d seen %0d", w, lo, hi, g);
    end
  endtask : chk_span
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask : wr
  task automatic rc(input logic [2:0] a, input logic [15:0] e, input string w);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CLK);
    REG_RD <= 1'b0;
    @(posedge CLK);
    #1 chk(w, e, REG_RDATA);
  endtask : rc
  // count edges until the alert pin is pulled low
  task automatic wt(input int lo, input int hi);
    int n;
    n = 0;
    #1;
    while (ALERT_OE_N !== 1'b0 && n < 3000) begin
      @(posedge CLK);
      #1;
      n++;
    end
    chk_span("cycles to alert", lo, hi, n);
  endtask : wt
  task automatic run(input logic [15:0] cfg, input int lo, input int hi);
    wr(`PMSA_OFS_CONFIG, cfg);
    repeat (2) @(posedge CLK);
    wt(lo - 2, hi - 2);
  endtask : run
  task automatic t_reset;
    rc(`PMSA_OFS_CONFIG, `PMSA_RST_CONFIG, "config");
    rc(`PMSA_OFS_MASK, 16'h0000, "mask");
  endtask : t_reset
  task automatic t_single;
    wr(`PMSA_OFS_CALIB, 16'h0A00);
    wr(`PMSA_OFS_MASK, 16'h0400);
    run(16'h0003, 280, 292);
    rc(`PMSA_OFS_SHUNT, 16'h1F40, "shunt");
    rc(`PMSA_OFS_BUS, 16'h2570, "bus");
    rc(`PMSA_OFS_CURRENT, 16'h2710, "current");
    rc(`PMSA_OFS_POWER, 16'h12B8, "power");
    rc(`PMSA_OFS_MASK, 16'h0408, "mask ready");
    repeat (400) @(posedge CLK);
    chk("alert after read", 16'h0001, {15'h0000, ALERT_OE_N});
    run(16'h0003, 280, 292);
    run(16'h0001, 140, 152);
  endtask : t_single
  task automatic t_timing;
    run(16'h0203, 1120, 1150);
    rc(`PMSA_OFS_CURRENT, 16'h2710, "average current");
    run(16'h000B, 344, 356);
    run(16'h0007, 280, 292);
    rc(`PMSA_OFS_MASK, 16'h0408, "mask ready");
    wt(1, 292);
  endtask : t_timing
  task automatic t_pd;
    wr(`PMSA_OFS_CONFIG, 16'h0000);
    repeat (2) @(posedge CLK);
    #1 chk("converter on", 16'h0000, {15'h0000, ANALOG_ON});
    rc(`PMSA_OFS_MASK, 16'h0408, "ready kept");
    wr(`PMSA_OFS_LIMIT, 16'h2000);
    rc(`PMSA_OFS_LIMIT, 16'h2000, "limit");
    run(16'h0003, 320, 334);
  endtask : t_pd
  task automatic t_alert;
    logic [4:0] f;
    for (int i = 0; i < 5; i++) begin
      f = 5'h10 >> i;
      // drop the flag left by the previous function
      wr(`PMSA_OFS_MASK, 16'h0400);
      wr(`PMSA_OFS_MASK, {f, 11'h400});
      run(16'h0003, 140, 292);
      repeat (150) @(posedge CLK);
      rc(`PMSA_OFS_MASK, {f, 6'h20, i == 1 || i == 2, 4'h8}, "function flag");
    end
    wr(`PMSA_OFS_MASK, 16'hA400);
    run(16'h0003, 280, 292);
    rc(`PMSA_OFS_MASK, 16'hA408, "priority");
    wr(`PMSA_OFS_MASK, 16'h2000);
    run(16'h0003, 279, 292);
    rc(`PMSA_OFS_MASK, 16'h2018, "bus over");
    wr(`PMSA_OFS_MASK, 16'h0002);
    repeat (3) @(posedge CLK);
    chk("inverted idle", 16'h0000, {15'h0000, ALERT_OE_N});
  endtask : t_alert
  task automatic t_uncal;
    wr(`PMSA_OFS_CALIB, 16'h0000);
    wr(`PMSA_OFS_MASK, 16'h0400);
    run(16'h0003, 280, 292);
    rc(`PMSA_OFS_CURRENT, 16'h0000, "uncal current");
    rc(`PMSA_OFS_POWER, 16'h0000, "uncal power");
    // latched under-limit holds through later clean compares
    wr(`PMSA_OFS_MASK, 16'h4001);
    run(16'h0005, 140, 152);
    @(posedge CLK);
    shunt_level <= 16'h2100;
    repeat (300) @(posedge CLK);
    chk("latched alert", 16'h0000, {15'h0000, ALERT_OE_N});
    rc(`PMSA_OFS_MASK, 16'h4019, "latched flag");
    repeat (3) @(posedge CLK);
    chk("alert after clear", 16'h0001, {15'h0000, ALERT_OE_N});
  endtask : t_uncal
  initial begin
    RST_N = 1'b0;
    REG_ADDR = 3'h0;
    REG_WR = 1'b0;
    REG_WDATA = 16'h0000;
    REG_RD = 1'b0;
    shunt_level = 16'h1F40;
    bus_level = 16'h2570;
    n_fail = 0;
    comparisons = 0;
    repeat (10) @(posedge CLK);
    RST_N <= 1'b1;
    t_reset();
    t_single();
    t_timing();
    t_pd();
    t_alert();
    t_uncal();
    final_report();
  end
  initial begin
    repeat (15000) @(posedge CLK);
    n_fail++;
    final_report();
  end
endmodule : tb_top
bind pmsa_core pmsa_core_monitor pmsa_core_monitor_i (.CLK(CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR),
  .REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .SHUNT_SAMPLE(SHUNT_SAMPLE),
  .BUS_SAMPLE(BUS_SAMPLE), .ANALOG_ON(ANALOG_ON), .ALERT_OUT(ALERT_OUT), .ALERT_OE_N(ALERT_OE_N));
